//--- rtl/bsc_top.sv
// Mode strap latch, bridge mode decode and packet header screen
module bsc_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_MODE_SELECT_HIGH,
  input wire logic I_MODE_SELECT_LOW,
  input wire logic I_REVERSE_SELECT,
  input wire logic [1:0] I_REQ_N_STRAP,
  input wire logic I_PERST_N,
  input wire logic I_PCI_RST_N,
  input wire logic I_CFG_WR,
  input wire logic [7:0] I_CFG_OFS,
  input wire logic [31:0] I_CFG_WDATA,
  input wire logic I_HDR_VALID,
  input wire logic I_HDR_DOWNSTREAM,
  input wire logic [1:0] I_HDR_FMT,
  input wire logic [4:0] I_HDR_TYPE,
  input wire logic [2:0] I_HDR_TC,
  input wire logic [9:0] I_HDR_LEN,
  output logic O_STRAP_VALID,
  output logic O_SMBUS_MODE,
  output logic O_SCL_OE_N,
  output logic O_SDA_OPEN_DRAIN,
  output logic O_INT_ARBITER,
  output logic O_REVERSE_MODE,
  output logic [3:0] O_PORT_TYPE,
  output logic O_CLK_PM_EN,
  output logic O_TWO_DEV_ONLY,
  output logic O_CLKOUT_TWO_IS_CLKREQ,
  output logic O_CLKOUT_THREE_IS_CLKRUN,
  output logic O_SHORT_INIT,
  output logic O_LOOPBACK_TEST,
  output logic O_BRIDGE_TEST,
  output logic [31:0] O_CHIP_CTRL,
  output logic O_ISO_EN,
  output logic [2:0] O_UP_TC,
  output logic O_TLP_VALID,
  output logic [2:0] O_TLP_CLASS,
  output logic O_TLP_4DW,
  output logic O_TLP_HAS_DATA,
  output logic [1:0] O_TLP_ROUTE,
  output logic [2:0] O_TLP_MSG_DEST,
  output logic O_TLP_LEN_ERR,
  output logic O_TLP_MALFORMED,
  output logic O_TLP_UNSUPPORTED,
  output logic O_TLP_TO_PCI
);

  // Strap latch sequence
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_RELEASE = 3'b010,
    ST_RUN = 3'b100
  } bsc_strap_e;

  // All state of the block
  typedef struct packed {
    bsc_strap_e st;
    logic src_pci;
    logic tm_hi;
    logic tm_lo;
    logic rev;
    logic [1:0] req;
    logic strap_valid;
    logic smbus;
    logic scl_oe_n;
    logic sda_od;
    logic int_arb;
    logic rev_mode;
    logic [3:0] port_type;
    logic clk_pm;
    logic two_dev;
    logic clkreq;
    logic clkrun;
    logic short_init;
    logic loopback;
    logic bridge_test;
    logic [31:0] chip_ctrl;
    logic iso_en;
    logic [2:0] up_tc;
    logic tlp_valid;
    logic [2:0] tlp_class;
    logic tlp_4dw;
    logic tlp_data;
    logic [1:0] tlp_route;
    logic [2:0] msg_dest;
    logic len_err;
    logic malformed;
    logic unsupported;
    logic to_pci;
  } bsc_state_s;

  bsc_state_s st_q;
  bsc_state_s st_d;

  logic [6:0] pin_raw;
  logic [6:0] pin_sync;
  logic s_tm_hi;
  logic s_tm_lo;
  logic s_rev;
  logic [1:0] s_req;
  logic s_perst_n;
  logic s_pci_rst_n;

  // Reset pins and straps are asynchronous to the reference clock
  assign pin_raw = {I_MODE_SELECT_HIGH, I_MODE_SELECT_LOW, I_REVERSE_SELECT, I_REQ_N_STRAP, I_PERST_N, I_PCI_RST_N};

  bsc_sync #(
    .W(7)
  ) u_pin_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async(pin_raw),
    .o_sync(pin_sync)
  );

  assign {s_tm_hi, s_tm_lo, s_rev, s_req, s_perst_n, s_pci_rst_n} = pin_sync;

  // Reset release source: PCI reset only for reverse mode under test strapping
  function automatic logic pick_pci_src(input logic tm_hi, input logic rev);
    pick_pci_src = tm_hi & rev;
  endfunction : pick_pci_src

  // Level of the chosen reset, high while that reset is released
  function automatic logic src_released(input logic use_pci, input logic perst_n, input logic pci_rst_n);
    src_released = use_pci ? pci_rst_n : perst_n;
  endfunction : src_released

  // Class of a header type code
  function automatic logic [2:0] type_class(input logic [4:0] t);
    logic [2:0] c;
    c = bsc_pkg::CLASS_NONE;
    if (t == bsc_pkg::TYPE_MEM || t == bsc_pkg::TYPE_MEM_LK) begin
      c = bsc_pkg::CLASS_MEM;
    end else if (t == bsc_pkg::TYPE_IO) begin
      c = bsc_pkg::CLASS_IO;
    end else if (t == bsc_pkg::TYPE_CFG0 || t == bsc_pkg::TYPE_CFG1) begin
      c = bsc_pkg::CLASS_CFG;
    end else if (t[4:3] == bsc_pkg::TYPE_MSG_HI) begin
      c = bsc_pkg::CLASS_MSG;
    end else if (t == bsc_pkg::TYPE_CPL || t == bsc_pkg::TYPE_CPL_LK) begin
      c = bsc_pkg::CLASS_CPL;
    end
    type_class = c;
  endfunction : type_class

  // Next state
  always_comb begin
    logic [2:0] cls;
    logic rel;
    logic [31:0] ctrl;
    logic [2:0] tc_sel;
    cls = bsc_pkg::CLASS_NONE;
    rel = 1'b0;
    ctrl = st_q.chip_ctrl;
    tc_sel = 3'h0;
    st_d = st_q;

    case (st_q.st)
      ST_HOLD: begin
        st_d.src_pci = pick_pci_src(s_tm_hi, s_rev);
        rel = src_released(pick_pci_src(s_tm_hi, s_rev), s_perst_n, s_pci_rst_n);
        if (rel) begin
          st_d.st = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        st_d.tm_hi = s_tm_hi;
        st_d.tm_lo = s_tm_lo;
        st_d.rev = s_rev;
        st_d.req = s_req;
        st_d.strap_valid = 1'b1;
        st_d.st = ST_RUN;
        if (!src_released(st_q.src_pci, s_perst_n, s_pci_rst_n)) begin
          st_d.strap_valid = 1'b0;
          st_d.st = ST_HOLD;
        end
      end
      ST_RUN: begin
        // hold until the same reset reasserts
        if (!src_released(st_q.src_pci, s_perst_n, s_pci_rst_n)) begin
          st_d.strap_valid = 1'b0;
          st_d.st = ST_HOLD;
        end
      end
      default: begin
        st_d.st = ST_HOLD;
        st_d.strap_valid = 1'b0;
      end
    endcase

    // Mode decode from the latched straps; steady straps assumed
    // all-low default mode
    st_d.int_arb = !st_d.tm_hi;
    st_d.smbus = !st_d.tm_hi && st_d.tm_lo;
    st_d.scl_oe_n = st_d.smbus;
    st_d.sda_od = st_d.smbus;
    st_d.rev_mode = st_d.rev;
    st_d.port_type = st_d.rev ? bsc_pkg::PORT_TYPE_REV : bsc_pkg::PORT_TYPE_FWD;
    st_d.clk_pm = !st_d.tm_hi && (st_d.req == bsc_pkg::REQ_STRAP_PM) && !st_d.rev;
    st_d.two_dev = st_d.clk_pm;
    st_d.clkreq = st_d.clk_pm;
    st_d.clkrun = st_d.clk_pm;
    st_d.short_init = st_d.tm_hi && st_d.tm_lo;
    st_d.loopback = st_d.tm_hi && !st_d.tm_lo && st_d.rev;
    st_d.bridge_test = st_d.tm_hi && !st_d.tm_lo && !st_d.rev;

    if (I_CFG_WR && I_CFG_OFS == bsc_pkg::CFG_OFS_CHIP_CTRL) begin
      ctrl = I_CFG_WDATA;
    end
    st_d.chip_ctrl = ctrl;
    st_d.iso_en = ctrl[bsc_pkg::ISO_EN_BIT];
    // upstream class choice, zero when mapping is off or select is zero
    tc_sel = ctrl[bsc_pkg::UP_TC_LSB +: bsc_pkg::TC_W];
    st_d.up_tc = (ctrl[bsc_pkg::ISO_EN_BIT] && tc_sel != bsc_pkg::TC_ZERO) ? tc_sel : bsc_pkg::TC_ZERO;

    // Header screen, one result per valid header
    st_d.tlp_valid = I_HDR_VALID;
    if (I_HDR_VALID) begin
      cls = type_class(I_HDR_TYPE);
      st_d.tlp_class = cls;
      st_d.tlp_4dw = I_HDR_FMT[bsc_pkg::FMT_4DW_BIT];
      st_d.tlp_data = I_HDR_FMT[bsc_pkg::FMT_DATA_BIT];
      // payload 1..64 dwords; a zero field means 1024 dwords
      st_d.len_err = I_HDR_FMT[bsc_pkg::FMT_DATA_BIT]
        && (I_HDR_LEN < bsc_pkg::LEN_MIN_DW || I_HDR_LEN > bsc_pkg::LEN_MAX_DW);
      case (cls)
        bsc_pkg::CLASS_MEM: begin
          st_d.tlp_route = bsc_pkg::ROUTE_ADDR;
        end
        bsc_pkg::CLASS_IO: begin
          st_d.tlp_route = bsc_pkg::ROUTE_ADDR;
        end
        bsc_pkg::CLASS_CFG: begin
          st_d.tlp_route = bsc_pkg::ROUTE_ID;
        end
        bsc_pkg::CLASS_CPL: begin
          st_d.tlp_route = bsc_pkg::ROUTE_ID;
        end
        bsc_pkg::CLASS_MSG: begin
          st_d.tlp_route = bsc_pkg::ROUTE_IMPL;
        end
        default: begin
          st_d.tlp_route = bsc_pkg::ROUTE_NONE;
        end
      endcase
      st_d.msg_dest = (cls == bsc_pkg::CLASS_MSG) ? I_HDR_TYPE[bsc_pkg::MSG_DEST_W-1:0] : 3'h0;
      // advanced-switching and other codes fall out as unsupported
      st_d.unsupported = (cls == bsc_pkg::CLASS_NONE);
      // nonzero class on messages, or downstream cfg/io
      st_d.malformed = (I_HDR_TC != bsc_pkg::TC_ZERO)
        && ((cls == bsc_pkg::CLASS_MSG)
        || (I_HDR_DOWNSTREAM && (cls == bsc_pkg::CLASS_CFG || cls == bsc_pkg::CLASS_IO)));
      // memory converts whatever its class; others only when clean
      st_d.to_pci = I_HDR_DOWNSTREAM && !st_d.len_err && !st_d.unsupported
        && ((cls == bsc_pkg::CLASS_MEM) || !st_d.malformed);
    end
  end

  // Single state register
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q <= '0;
      st_q.st <= ST_HOLD;
      st_q.port_type <= bsc_pkg::PORT_TYPE_FWD;
      st_q.int_arb <= 1'b1;
      // Request straps rest at their idle level, so power management stays off until the latch
      st_q.req <= ~bsc_pkg::REQ_STRAP_PM;
      st_q.chip_ctrl <= bsc_pkg::CHIP_CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign O_STRAP_VALID = st_q.strap_valid;
  assign O_SMBUS_MODE = st_q.smbus;
  assign O_SCL_OE_N = st_q.scl_oe_n;
  assign O_SDA_OPEN_DRAIN = st_q.sda_od;
  assign O_INT_ARBITER = st_q.int_arb;
  assign O_REVERSE_MODE = st_q.rev_mode;
  assign O_PORT_TYPE = st_q.port_type;
  assign O_CLK_PM_EN = st_q.clk_pm;
  assign O_TWO_DEV_ONLY = st_q.two_dev;
  assign O_CLKOUT_TWO_IS_CLKREQ = st_q.clkreq;
  assign O_CLKOUT_THREE_IS_CLKRUN = st_q.clkrun;
  assign O_SHORT_INIT = st_q.short_init;
  assign O_LOOPBACK_TEST = st_q.loopback;
  assign O_BRIDGE_TEST = st_q.bridge_test;
  assign O_CHIP_CTRL = st_q.chip_ctrl;
  assign O_ISO_EN = st_q.iso_en;
  assign O_UP_TC = st_q.up_tc;
  assign O_TLP_VALID = st_q.tlp_valid;
  assign O_TLP_CLASS = st_q.tlp_class;
  assign O_TLP_4DW = st_q.tlp_4dw;
  assign O_TLP_HAS_DATA = st_q.tlp_data;
  assign O_TLP_ROUTE = st_q.tlp_route;
  assign O_TLP_MSG_DEST = st_q.msg_dest;
  assign O_TLP_LEN_ERR = st_q.len_err;
  assign O_TLP_MALFORMED = st_q.malformed;
  assign O_TLP_UNSUPPORTED = st_q.unsupported;
  assign O_TLP_TO_PCI = st_q.to_pci;

endmodule : bsc_top

//--- shared/bsc_pkg.sv
// Constants shared by the strap decoder and packet screen
package bsc_pkg;

  // Header format field bits
  localparam int FMT_W = 2;
  localparam int FMT_4DW_BIT = 0;
  localparam int FMT_DATA_BIT = 1;

  // Header type codes (5 bits)
  localparam int TYPE_W = 5;
  localparam logic [4:0] TYPE_MEM = 5'h00;
  localparam logic [4:0] TYPE_MEM_LK = 5'h01;
  localparam logic [4:0] TYPE_IO = 5'h02;
  localparam logic [4:0] TYPE_CFG0 = 5'h04;
  localparam logic [4:0] TYPE_CFG1 = 5'h05;
  localparam logic [4:0] TYPE_CPL = 5'h0A;
  localparam logic [4:0] TYPE_CPL_LK = 5'h0B;
  localparam logic [1:0] TYPE_MSG_HI = 2'h2;
  localparam int MSG_DEST_W = 3;

  // Traffic class
  localparam int TC_W = 3;
  localparam logic [2:0] TC_ZERO = 3'h0;

  // Payload length limits in dwords
  localparam int LEN_W = 10;
  localparam logic [9:0] LEN_MIN_DW = 10'h001;
  localparam logic [9:0] LEN_MAX_DW = 10'h040;

  // Packet class codes
  localparam int CLASS_W = 3;
  localparam logic [2:0] CLASS_NONE = 3'h0;
  localparam logic [2:0] CLASS_MEM = 3'h1;
  localparam logic [2:0] CLASS_IO = 3'h2;
  localparam logic [2:0] CLASS_CFG = 3'h3;
  localparam logic [2:0] CLASS_MSG = 3'h4;
  localparam logic [2:0] CLASS_CPL = 3'h5;

  // Routing method codes
  localparam int ROUTE_W = 2;
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_ADDR = 2'h1;
  localparam logic [1:0] ROUTE_ID = 2'h2;
  localparam logic [1:0] ROUTE_IMPL = 2'h3;

  // Chip control dword and its fields
  localparam int CFG_OFS_W = 8;
  localparam logic [7:0] CFG_OFS_CHIP_CTRL = 8'h40;
  localparam int ISO_EN_BIT = 26;
  localparam int UP_TC_LSB = 27;
  localparam logic [31:0] CHIP_CTRL_RST = 32'h0000_0000;

  // Device/port type values
  localparam logic [3:0] PORT_TYPE_FWD = 4'h7;
  localparam logic [3:0] PORT_TYPE_REV = 4'h8;

  // Request strap value that enables clock power management
  localparam logic [1:0] REQ_STRAP_PM = 2'h0;

endpackage : bsc_pkg

//--- rtl/bsc_sync.sv
// Two-flop synchroniser for asynchronous pin levels
module bsc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } bsc_sync_s;

  bsc_sync_s st_q;
  bsc_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = i_async;
    st_d.stab = st_q.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.stab;

endmodule : bsc_sync

//--- test/bsc_strap_src.sv
// Board-side model driving the mode straps and both reset pins
module bsc_strap_src (
  input wire logic i_want_high,
  input wire logic i_want_low,
  input wire logic i_want_rev,
  input wire logic [1:0] i_want_req,
  input wire logic i_perst_go,
  input wire logic i_pci_go,
  output logic o_mode_high,
  output logic o_mode_low,
  output logic o_rev,
  output logic [1:0] o_req_n,
  output logic o_perst_n,
  output logic o_pci_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // steady straps
  // Straps move only while both resets are held, never in normal operation
  always_latch begin
    if (!i_perst_go && !i_pci_go) begin
      o_mode_high <= i_want_high;
      o_mode_low <= i_want_low;
      o_rev <= i_want_rev;
      o_req_n <= i_want_req;
    end
  end
  // Reset pins follow the board's power-up sequencing
  assign o_perst_n = i_perst_go;
  assign o_pci_rst_n = i_pci_go;
endmodule : bsc_strap_src

//--- test/bsc_top_sva.sv
// Concurrent checks on the strap decoder and packet screen ports
module bsc_top_sva (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CFG_WR,
  input wire logic [7:0] I_CFG_OFS,
  input wire logic [31:0] I_CFG_WDATA,
  input wire logic I_HDR_VALID,
  input wire logic I_HDR_DOWNSTREAM,
  input wire logic [1:0] I_HDR_FMT,
  input wire logic [4:0] I_HDR_TYPE,
  input wire logic [2:0] I_HDR_TC,
  input wire logic [9:0] I_HDR_LEN,
  input wire logic O_STRAP_VALID,
  input wire logic O_SMBUS_MODE,
  input wire logic O_SCL_OE_N,
  input wire logic O_SDA_OPEN_DRAIN,
  input wire logic O_REVERSE_MODE,
  input wire logic [3:0] O_PORT_TYPE,
  input wire logic O_ISO_EN,
  input wire logic [2:0] O_UP_TC,
  input wire logic O_TLP_VALID,
  input wire logic O_TLP_4DW,
  input wire logic O_TLP_HAS_DATA,
  input wire logic [1:0] O_TLP_ROUTE,
  input wire logic [2:0] O_TLP_MSG_DEST,
  input wire logic O_TLP_LEN_ERR,
  input wire logic O_TLP_MALFORMED,
  input wire logic O_TLP_TO_PCI
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  hdr_pulse_a: assert property (I_HDR_VALID |=> O_TLP_VALID)
    else $error("header result pulse missing");
  fmt_decode_a: assert property (I_HDR_VALID |=>
    O_TLP_4DW == $past(I_HDR_FMT[0]) && O_TLP_HAS_DATA == $past(I_HDR_FMT[1])) else $error("format decode wrong");
  len_check_a: assert property (I_HDR_VALID |=> O_TLP_LEN_ERR ==
    ($past(I_HDR_FMT[1]) && ($past(I_HDR_LEN) == 10'h000 || $past(I_HDR_LEN) > 10'h040)))
    else $error("length check wrong");
  cfg_route_a: assert property (I_HDR_VALID && I_HDR_TYPE[4:1] == 4'h2 |=>
    O_TLP_ROUTE == bsc_pkg::ROUTE_ID) else $error("config not routed by id");
  msg_dest_a: assert property (I_HDR_VALID && I_HDR_TYPE[4:3] == bsc_pkg::TYPE_MSG_HI |=>
    O_TLP_ROUTE == bsc_pkg::ROUTE_IMPL && O_TLP_MSG_DEST == $past(I_HDR_TYPE[2:0])) else $error("message route wrong");
  tc_malformed_a: assert property (I_HDR_VALID && I_HDR_DOWNSTREAM && I_HDR_TC != 3'h0 &&
    (I_HDR_TYPE == bsc_pkg::TYPE_IO || I_HDR_TYPE[4:1] == 4'h2 || I_HDR_TYPE[4:3] == bsc_pkg::TYPE_MSG_HI)
    |=> O_TLP_MALFORMED && !O_TLP_TO_PCI) else $error("nonzero class not malformed");
  mem_to_pci_a: assert property (I_HDR_VALID && I_HDR_DOWNSTREAM && I_HDR_TYPE == bsc_pkg::TYPE_MEM &&
    (!I_HDR_FMT[1] || (I_HDR_LEN != 10'h000 && I_HDR_LEN <= 10'h040)) |=> O_TLP_TO_PCI)
    else $error("memory packet not forwarded");
  iso_write_a: assert property (I_CFG_WR && I_CFG_OFS == bsc_pkg::CFG_OFS_CHIP_CTRL |=>
    O_ISO_EN == $past(I_CFG_WDATA[26]) && O_UP_TC == ($past(I_CFG_WDATA[26]) ? $past(I_CFG_WDATA[29:27]) : 3'h0))
    else $error("isochronous control wrong");
  port_type_a: assert property (O_PORT_TYPE == (O_REVERSE_MODE ? 4'h8 : 4'h7))
    else $error("port type does not follow direction");
  serial_role_a: assert property (O_SCL_OE_N == O_SMBUS_MODE && O_SDA_OPEN_DRAIN == O_SMBUS_MODE)
    else $error("serial pin roles inconsistent");
  strap_hold_a: assert property (O_STRAP_VALID && $past(O_STRAP_VALID) |->
    $stable(O_REVERSE_MODE) && $stable(O_SMBUS_MODE)) else $error("latched mode moved");
  cover property (I_HDR_VALID ##1 I_HDR_VALID);
  cover property ($rose(O_STRAP_VALID) && O_REVERSE_MODE);
  cover property ($rose(O_ISO_EN));
endmodule : bsc_top_sva
bind bsc_top bsc_top_sva u_sva (.I_REF_CLK, .I_RST, .I_CFG_WR, .I_CFG_OFS, .I_CFG_WDATA, .I_HDR_VALID,
  .I_HDR_DOWNSTREAM, .I_HDR_FMT, .I_HDR_TYPE, .I_HDR_TC, .I_HDR_LEN, .O_STRAP_VALID, .O_SMBUS_MODE,
  .O_SCL_OE_N, .O_SDA_OPEN_DRAIN, .O_REVERSE_MODE, .O_PORT_TYPE, .O_ISO_EN, .O_UP_TC, .O_TLP_VALID,
  .O_TLP_4DW, .O_TLP_HAS_DATA, .O_TLP_ROUTE, .O_TLP_MSG_DEST, .O_TLP_LEN_ERR, .O_TLP_MALFORMED, .O_TLP_TO_PCI);

//--- test/bsc_top_bench.sv
// Self-checking bench for strap latching, chip control and packet screening
module bsc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_REF_CLK, I_RST, I_MODE_SELECT_HIGH, I_MODE_SELECT_LOW, I_REVERSE_SELECT, I_PERST_N, I_PCI_RST_N;
  logic I_CFG_WR, I_HDR_VALID, I_HDR_DOWNSTREAM, O_STRAP_VALID, O_SMBUS_MODE, O_SCL_OE_N, O_SDA_OPEN_DRAIN;
  logic [1:0] I_REQ_N_STRAP, I_HDR_FMT, O_TLP_ROUTE;
  logic [7:0] I_CFG_OFS;
  logic [31:0] I_CFG_WDATA, O_CHIP_CTRL;
  logic [4:0] I_HDR_TYPE;
  logic [2:0] I_HDR_TC, O_UP_TC, O_TLP_CLASS, O_TLP_MSG_DEST;
  logic [9:0] I_HDR_LEN;
  logic [3:0] O_PORT_TYPE;
  logic O_INT_ARBITER, O_REVERSE_MODE, O_CLK_PM_EN, O_TWO_DEV_ONLY, O_CLKOUT_TWO_IS_CLKREQ;
  logic O_CLKOUT_THREE_IS_CLKRUN, O_SHORT_INIT, O_LOOPBACK_TEST, O_BRIDGE_TEST, O_ISO_EN, O_TLP_VALID;
  logic O_TLP_4DW, O_TLP_HAS_DATA, O_TLP_LEN_ERR, O_TLP_MALFORMED, O_TLP_UNSUPPORTED, O_TLP_TO_PCI;
  logic want_h, want_l, want_r, perst_go, pci_go;
  logic [1:0] want_req;
  int fails, n_compared;

  bsc_top dut (.I_REF_CLK, .I_RST, .I_MODE_SELECT_HIGH, .I_MODE_SELECT_LOW, .I_REVERSE_SELECT, .I_REQ_N_STRAP,
    .I_PERST_N, .I_PCI_RST_N, .I_CFG_WR, .I_CFG_OFS, .I_CFG_WDATA, .I_HDR_VALID, .I_HDR_DOWNSTREAM, .I_HDR_FMT,
    .I_HDR_TYPE, .I_HDR_TC, .I_HDR_LEN, .O_STRAP_VALID, .O_SMBUS_MODE, .O_SCL_OE_N, .O_SDA_OPEN_DRAIN,
    .O_INT_ARBITER, .O_REVERSE_MODE, .O_PORT_TYPE, .O_CLK_PM_EN, .O_TWO_DEV_ONLY, .O_CLKOUT_TWO_IS_CLKREQ,
    .O_CLKOUT_THREE_IS_CLKRUN, .O_SHORT_INIT, .O_LOOPBACK_TEST, .O_BRIDGE_TEST, .O_CHIP_CTRL, .O_ISO_EN, .O_UP_TC,
    .O_TLP_VALID, .O_TLP_CLASS, .O_TLP_4DW, .O_TLP_HAS_DATA, .O_TLP_ROUTE, .O_TLP_MSG_DEST, .O_TLP_LEN_ERR,
    .O_TLP_MALFORMED, .O_TLP_UNSUPPORTED, .O_TLP_TO_PCI);
  bsc_strap_src u_src (.i_want_high(want_h), .i_want_low(want_l), .i_want_rev(want_r), .i_want_req(want_req),
    .i_perst_go(perst_go), .i_pci_go(pci_go), .o_mode_high(I_MODE_SELECT_HIGH), .o_mode_low(I_MODE_SELECT_LOW),
    .o_rev(I_REVERSE_SELECT), .o_req_n(I_REQ_N_STRAP), .o_perst_n(I_PERST_N), .o_pci_rst_n(I_PCI_RST_N));

  // 20 MHz reference
  initial begin
    I_REF_CLK = 1'b0;
    forever #25 I_REF_CLK = ~I_REF_CLK;
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait on the strap-valid level; a hang ends the run
  task automatic wait_sv(input logic want);
    for (int i = 0; i < 20 && O_STRAP_VALID !== want; i++) @(negedge I_REF_CLK);
    if (O_STRAP_VALID !== want) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, O_STRAP_VALID, want);
      results();
    end
  endtask : wait_sv

  // One full reset cycle with new straps, then every mode output compared
  task automatic strap(input logic h, input logic l, input logic r, input logic [1:0] req);
    logic pm;
    pm = !h && req == 2'h0 && !r;
    perst_go = 1'b0;
    pci_go = 1'b0;
    wait_sv(1'b0);
    want_h = h;
    want_l = l;
    want_r = r;
    want_req = req;
    repeat (4) @(negedge I_REF_CLK);
    perst_go = 1'b1;
    // Reverse test strapping waits for the bus reset, not the express one
    if (h && r) begin
      repeat (8) @(negedge I_REF_CLK);
      chk(O_STRAP_VALID, 1'b0);
      pci_go = 1'b1;
    end
    wait_sv(1'b1);
    chk({O_SMBUS_MODE, O_SCL_OE_N, O_SDA_OPEN_DRAIN, O_INT_ARBITER, O_REVERSE_MODE, O_PORT_TYPE},
      {!h && l, !h && l, !h && l, !h, r, r ? 4'h8 : 4'h7});
    chk({O_CLK_PM_EN, O_TWO_DEV_ONLY, O_CLKOUT_TWO_IS_CLKREQ, O_CLKOUT_THREE_IS_CLKRUN}, {4{pm}});
    chk({O_SHORT_INIT, O_LOOPBACK_TEST, O_BRIDGE_TEST}, {h && l, h && !l && r, h && !l && !r});
    $display("strap test %b%b%b done", h, l, r);
  endtask : strap

  // Chip control write; the task raises the strobe and leaves it high between back-to-back writes, the caller drops it
  task automatic cfg(input logic [7:0] ofs, input logic [31:0] d, input logic [31:0] ctrl, input logic [3:0] iso_tc);
    I_CFG_WR = 1'b1;
    I_CFG_OFS = ofs;
    I_CFG_WDATA = d;
    @(negedge I_REF_CLK);
    chk(O_CHIP_CTRL, ctrl);
    chk({O_ISO_EN, O_UP_TC}, iso_tc);
  endtask : cfg

  // Header screen; expect packs class, route, length error, malformed, unsupported, to-PCI
  task automatic hdr(input logic ds, input logic [1:0] fmt, input logic [4:0] typ, input logic [2:0] tc,
    input logic [9:0] len, input logic [8:0] expect_v);
    I_HDR_VALID = 1'b1;
    I_HDR_DOWNSTREAM = ds;
    I_HDR_FMT = fmt;
    I_HDR_TYPE = typ;
    I_HDR_TC = tc;
    I_HDR_LEN = len;
    @(negedge I_REF_CLK);
    chk(O_TLP_VALID, 1'b1);
    chk({O_TLP_4DW, O_TLP_HAS_DATA}, {fmt[0], fmt[1]});
    chk({O_TLP_CLASS, O_TLP_ROUTE, O_TLP_LEN_ERR, O_TLP_MALFORMED, O_TLP_UNSUPPORTED, O_TLP_TO_PCI}, expect_v);
    if (typ[4:3] == bsc_pkg::TYPE_MSG_HI) chk(O_TLP_MSG_DEST, typ[2:0]);
  endtask : hdr

  initial begin
    {I_RST, I_CFG_WR, I_HDR_VALID, I_HDR_DOWNSTREAM, I_HDR_FMT, I_HDR_TYPE, I_HDR_TC} = {1'b1, 13'h0000};
    {I_CFG_OFS, I_CFG_WDATA, I_HDR_LEN} = 50'h0;
    {want_h, want_l, want_r, want_req, perst_go, pci_go} = 7'h00;
    {fails, n_compared} = 64'h0;
    repeat (6) @(negedge I_REF_CLK);
    I_RST = 1'b0;
    @(negedge I_REF_CLK);
    chk({O_ISO_EN, O_UP_TC, O_STRAP_VALID}, 5'h00);
    chk(O_CHIP_CTRL, bsc_pkg::CHIP_CTRL_RST);
    // Before any latch the modes must read as the all-low default, with no power management
    chk({O_CLK_PM_EN, O_SMBUS_MODE, O_INT_ARBITER, O_PORT_TYPE}, 7'h17);
    // Back-to-back writes; the wrong offset must be ignored
    cfg(8'h44, 32'h0400_0000, 32'h0, 4'h0);
    cfg(8'h40, 32'h2C00_0000, 32'h2C00_0000, 4'hD);
    cfg(8'h40, 32'h3C00_0000, 32'h3C00_0000, 4'hF);
    cfg(8'h40, 32'h3800_0000, 32'h3800_0000, 4'h0);
    cfg(8'h40, 32'h0C00_0000, 32'h0C00_0000, 4'h9);
    I_CFG_WR = 1'b0;
    $display("config test done");
    // Back-to-back headers across every class and boundary length
    hdr(1'b1, 2'h2, bsc_pkg::TYPE_MEM, 3'h3, 10'h004, 9'h051);
    hdr(1'b1, 2'h3, bsc_pkg::TYPE_MEM, 3'h7, 10'h040, 9'h051);
    hdr(1'b1, 2'h2, bsc_pkg::TYPE_MEM, 3'h0, 10'h041, 9'h058);
    hdr(1'b1, 2'h2, bsc_pkg::TYPE_MEM, 3'h0, 10'h000, 9'h058);
    hdr(1'b1, 2'h0, bsc_pkg::TYPE_MEM, 3'h0, 10'h000, 9'h051);
    hdr(1'b1, 2'h2, bsc_pkg::TYPE_IO, 3'h1, 10'h001, 9'h094);
    hdr(1'b1, 2'h0, bsc_pkg::TYPE_IO, 3'h0, 10'h000, 9'h091);
    hdr(1'b1, 2'h0, bsc_pkg::TYPE_CFG0, 3'h2, 10'h000, 9'h0E4);
    hdr(1'b1, 2'h0, bsc_pkg::TYPE_CFG1, 3'h0, 10'h000, 9'h0E1);
    hdr(1'b1, 2'h1, 5'h14, 3'h0, 10'h000, 9'h131);
    hdr(1'b1, 2'h1, 5'h13, 3'h5, 10'h000, 9'h134);
    hdr(1'b0, 2'h1, 5'h10, 3'h1, 10'h000, 9'h134);
    hdr(1'b0, 2'h2, bsc_pkg::TYPE_MEM, 3'h2, 10'h010, 9'h050);
    hdr(1'b1, 2'h2, bsc_pkg::TYPE_CPL, 3'h0, 10'h001, 9'h161);
    hdr(1'b1, 2'h0, 5'h1F, 3'h0, 10'h000, 9'h002);
    I_HDR_VALID = 1'b0;
    @(negedge I_REF_CLK);
    chk(O_TLP_VALID, 1'b0);
    $display("header test done");
    strap(1'b0, 1'b0, 1'b0, 2'h0);
    strap(1'b0, 1'b1, 1'b1, 2'h3);
    strap(1'b0, 1'b0, 1'b1, 2'h0);
    strap(1'b0, 1'b0, 1'b0, 2'h1);
    strap(1'b1, 1'b1, 1'b0, 2'h3);
    strap(1'b1, 1'b0, 1'b1, 2'h3);
    strap(1'b1, 1'b0, 1'b0, 2'h3);
    results();
  end
endmodule : bsc_top_bench
